/* src/gpc_pkg.sv */
// Package: register map, field positions and reset values of the port block
package gpc_pkg;
    // Byte offsets of the base registers (alias offsets add 4/8/12)
    localparam logic [7:0] DIR_OFF = 8'h00;
    localparam logic [7:0] LAT_OFF = 8'h10;
    localparam logic [7:0] PIN_OFF = 8'h20;
    localparam logic [7:0] ODC_OFF = 8'h30;
    localparam logic [7:0] ANS_OFF = 8'h40;
    localparam logic [7:0] CNC_OFF = 8'h50;
    localparam logic [7:0] CE0_OFF = 8'h60;
    localparam logic [7:0] CE1_OFF = 8'h70;
    localparam logic [7:0] CST_OFF = 8'h80;
    localparam logic [7:0] CEF_OFF = 8'h90;
    localparam logic [7:0] MRG_OFF = 8'ha0;
    localparam logic [7:0] WIDE_OFF = 8'hb0;
    // Alias selector in address bits 3:2
    localparam logic [1:0] AL_BASE = 2'h0;
    localparam logic [1:0] AL_CLR = 2'h1;
    localparam logic [1:0] AL_SET = 2'h2;
    localparam logic [1:0] AL_INV = 2'h3;
    // Control register fields
    localparam int CN_ON_BIT = 15;
    localparam int CN_STYLE_BIT = 11;
    localparam int MRG_BIT = 0;
    // Reset values
    localparam logic [15:0] DIR_RST = 16'hffff;
    localparam logic [15:0] ANS_RST = 16'hffff;
    localparam logic [15:0] ZERO_RST = 16'h0000;
    // Read path depth in system clocks
    localparam int SYNC_STAGES = 3;
endpackage

/* src/gpc_port.sv */
// Two-port GPIO block with atomic aliases, merging and change notify
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
module gpc_port #(
    parameter int PW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2*PW-1:0] pin_in,
    output logic [2*PW-1:0] pin_out,
    output logic [2*PW-1:0] pin_oe_n,
    output logic [2*PW-1:0] analog_mode,
    output logic [1:0] change_irq
);
    localparam int NP = 2;

    // Per-port state, index 0 is the lower port
    logic [PW-1:0] direction_reg [NP], direction_next [NP];
    logic [PW-1:0] output_latch_reg [NP], output_latch_next [NP];
    logic [PW-1:0] open_drain_ctrl_reg [NP], open_drain_ctrl_next [NP];
    logic [PW-1:0] analog_select_reg [NP], analog_select_next [NP];
    logic [PW-1:0] change_notify_ctrl_reg [NP], change_notify_ctrl_next [NP];
    logic [PW-1:0] change_enable_low_reg [NP], change_enable_low_next [NP];
    logic [PW-1:0] change_enable_high_reg [NP], change_enable_high_next [NP];
    logic [PW-1:0] change_status_reg [NP], change_status_next [NP];
    logic [PW-1:0] change_event_flag_reg [NP], change_event_flag_next [NP];
    logic [PW-1:0] last_read_reg [NP], last_read_next [NP];
    logic [PW-1:0] prev_pin_reg [NP], prev_pin_next [NP];
    logic wide_merge_enable_reg, wide_merge_enable_next;
    logic [31:0] prdata_reg, prdata_next;

    // Synchronised pin levels
    logic [2*PW-1:0] pin_sync;
    logic [PW-1:0] pin_level [NP];

    // Bus decode
    logic wr_en, rd_en, hit;
    logic [1:0] alias_sel;
    logic [7:0] base_off;
    logic [0:0] port_sel;

    // Pins pass three flip-flops before the read path sees them
    gpc_sync #(
        .WIDTH(2*PW),
        .STAGES(gpc_pkg::SYNC_STAGES)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pin_in),
        .q(pin_sync)
    );

    // Analog pins read as low level
    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            pin_level[p] = pin_sync[p*PW +: PW] & ~analog_select_reg[p];
        end
    end

    // Address split: bit 8 picks port, 7:4 register, 3:2 alias
    assign port_sel = paddr[8];
    assign base_off = {paddr[7:4], 4'h0};
    assign alias_sel = paddr[3:2];
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    // Zero wait states; every access completes in one access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // Apply a write through base or alias form
    function automatic logic [PW-1:0] apply_wr(
        input logic [PW-1:0] cur,
        input logic [1:0] sel,
        input logic [PW-1:0] val
    );
        logic [PW-1:0] r;
        r = cur;
        unique case (sel)
            gpc_pkg::AL_BASE: r = val;
            gpc_pkg::AL_CLR: r = cur & ~val;
            gpc_pkg::AL_SET: r = cur | val;
            gpc_pkg::AL_INV: r = cur ^ val;
        endcase
        return r;
    endfunction

    // Next-state logic for registers, detection and read data
    always_comb
    begin
        logic [PW-1:0] wd;
        logic [PW-1:0] evt;
        logic [PW-1:0] rise;
        logic [PW-1:0] fall;
        logic [PW-1:0] mism;
        logic wsel;
        logic [PW-1:0] mrg;
        wd = pwdata[PW-1:0];
        mrg = '0;
        evt = '0;
        rise = '0;
        fall = '0;
        mism = '0;
        wsel = 1'b0;
        hit = 1'b0;
        prdata_next = prdata_reg;
        wide_merge_enable_next = wide_merge_enable_reg;
        direction_next = direction_reg;
        output_latch_next = output_latch_reg;
        open_drain_ctrl_next = open_drain_ctrl_reg;
        analog_select_next = analog_select_reg;
        change_notify_ctrl_next = change_notify_ctrl_reg;
        change_enable_low_next = change_enable_low_reg;
        change_enable_high_next = change_enable_high_reg;
        change_status_next = change_status_reg;
        change_event_flag_next = change_event_flag_reg;
        last_read_next = last_read_reg;
        prev_pin_next = pin_level;
        // Merge and wide view live only in the lower port's space
        if (base_off == gpc_pkg::MRG_OFF || base_off == gpc_pkg::WIDE_OFF)
        begin
            hit = (port_sel == 1'b0);
        end
        else
        begin
            hit = (base_off <= gpc_pkg::CEF_OFF);
        end
        for (int p = 0; p < NP; p++)
        begin
            wsel = wr_en && (port_sel == p[0]);
            if (wsel)
            begin
                unique case (base_off)
                    gpc_pkg::DIR_OFF: direction_next[p] =
                        apply_wr(direction_reg[p], alias_sel, wd);
                    // Pin-level address writes land in the latch
                    gpc_pkg::LAT_OFF, gpc_pkg::PIN_OFF: output_latch_next[p] =
                        apply_wr(output_latch_reg[p], alias_sel, wd);
                    gpc_pkg::ODC_OFF: open_drain_ctrl_next[p] =
                        apply_wr(open_drain_ctrl_reg[p], alias_sel, wd);
                    gpc_pkg::ANS_OFF: analog_select_next[p] =
                        apply_wr(analog_select_reg[p], alias_sel, wd);
                    gpc_pkg::CNC_OFF: change_notify_ctrl_next[p] =
                        apply_wr(change_notify_ctrl_reg[p], alias_sel, wd);
                    gpc_pkg::CE0_OFF: change_enable_low_next[p] =
                        apply_wr(change_enable_low_reg[p], alias_sel, wd);
                    gpc_pkg::CE1_OFF: change_enable_high_next[p] =
                        apply_wr(change_enable_high_reg[p], alias_sel, wd);
                    gpc_pkg::CEF_OFF: change_event_flag_next[p] =
                        apply_wr(change_event_flag_reg[p], alias_sel, wd);
                    default: ;
                endcase
            end
            // Reading the pin level refreshes the mismatch reference
            if (rd_en && port_sel == p[0] && base_off == gpc_pkg::PIN_OFF
                && alias_sel == gpc_pkg::AL_BASE)
            begin
                last_read_next[p] = pin_level[p];
                change_status_next[p] = '0;
            end
            // Wide read of the lower port also counts for the upper
            if (rd_en && port_sel == 1'b0 && base_off == gpc_pkg::WIDE_OFF
                && alias_sel == gpc_pkg::AL_BASE)
            begin
                last_read_next[p] = pin_level[p];
                change_status_next[p] = '0;
            end
            // Status tracks difference from the reference in force next
            // cycle, so a read clears it instead of re-setting it
            change_status_next[p] = change_status_next[p]
                | (pin_level[p] ^ last_read_next[p]);
            rise = pin_level[p] & ~prev_pin_reg[p];
            fall = ~pin_level[p] & prev_pin_reg[p];
            mism = pin_level[p] ^ last_read_reg[p];
            if (change_notify_ctrl_reg[p][gpc_pkg::CN_STYLE_BIT])
            begin
                // Edge style: low enable rising, high enable falling
                evt = (rise & change_enable_low_reg[p])
                    | (fall & change_enable_high_reg[p]);
            end
            else
            begin
                evt = mism & change_enable_low_reg[p];
            end
            // Only enabled port and input pins raise events
            evt = evt & direction_reg[p];
            if (!change_notify_ctrl_reg[p][gpc_pkg::CN_ON_BIT])
            begin
                evt = '0;
            end
            // Hardware set wins over a same-cycle software clear
            change_event_flag_next[p] = change_event_flag_next[p] | evt;
        end
        if (wr_en && port_sel == 1'b0 && base_off == gpc_pkg::MRG_OFF)
        begin
            mrg = apply_wr({{(PW-1){1'b0}}, wide_merge_enable_reg},
                alias_sel, wd);
            wide_merge_enable_next = mrg[gpc_pkg::MRG_BIT];
        end
        // Read mux, captured at the setup edge so data stands in access
        if (psel && !penable && !pwrite)
        begin
            prdata_next = '0;
            if (alias_sel == gpc_pkg::AL_BASE && hit)
            begin
                unique case (base_off)
                    gpc_pkg::DIR_OFF: prdata_next[PW-1:0] = direction_reg[port_sel];
                    gpc_pkg::LAT_OFF: prdata_next[PW-1:0] = output_latch_reg[port_sel];
                    gpc_pkg::PIN_OFF: prdata_next[PW-1:0] = pin_level[port_sel];
                    gpc_pkg::ODC_OFF: prdata_next[PW-1:0] = open_drain_ctrl_reg[port_sel];
                    gpc_pkg::ANS_OFF: prdata_next[PW-1:0] = analog_select_reg[port_sel];
                    gpc_pkg::CNC_OFF: prdata_next[PW-1:0] = change_notify_ctrl_reg[port_sel];
                    gpc_pkg::CE0_OFF: prdata_next[PW-1:0] = change_enable_low_reg[port_sel];
                    gpc_pkg::CE1_OFF: prdata_next[PW-1:0] = change_enable_high_reg[port_sel];
                    gpc_pkg::CST_OFF: prdata_next[PW-1:0] = change_status_reg[port_sel];
                    gpc_pkg::CEF_OFF: prdata_next[PW-1:0] = change_event_flag_reg[port_sel];
                    gpc_pkg::MRG_OFF: prdata_next[gpc_pkg::MRG_BIT] = wide_merge_enable_reg;
                    // Lower port only merges with the next one
                    gpc_pkg::WIDE_OFF:
                    begin
                        prdata_next[PW-1:0] = pin_level[0];
                        if (wide_merge_enable_reg)
                        begin
                            prdata_next[2*PW-1:PW] = pin_level[1];
                        end
                    end
                    default: ;
                endcase
            end
            else
            begin
                prdata_next = '0;
            end
        end
    end

    // Register all state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int p = 0; p < NP; p++)
            begin
                direction_reg[p] <= gpc_pkg::DIR_RST;
                output_latch_reg[p] <= gpc_pkg::ZERO_RST;
                open_drain_ctrl_reg[p] <= gpc_pkg::ZERO_RST;
                analog_select_reg[p] <= gpc_pkg::ANS_RST;
                change_notify_ctrl_reg[p] <= gpc_pkg::ZERO_RST;
                change_enable_low_reg[p] <= gpc_pkg::ZERO_RST;
                change_enable_high_reg[p] <= gpc_pkg::ZERO_RST;
                change_status_reg[p] <= gpc_pkg::ZERO_RST;
                change_event_flag_reg[p] <= gpc_pkg::ZERO_RST;
                last_read_reg[p] <= gpc_pkg::ZERO_RST;
                prev_pin_reg[p] <= gpc_pkg::ZERO_RST;
            end
            wide_merge_enable_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            direction_reg <= direction_next;
            output_latch_reg <= output_latch_next;
            open_drain_ctrl_reg <= open_drain_ctrl_next;
            analog_select_reg <= analog_select_next;
            change_notify_ctrl_reg <= change_notify_ctrl_next;
            change_enable_low_reg <= change_enable_low_next;
            change_enable_high_reg <= change_enable_high_next;
            change_status_reg <= change_status_next;
            change_event_flag_reg <= change_event_flag_next;
            last_read_reg <= last_read_next;
            prev_pin_reg <= prev_pin_next;
            wide_merge_enable_reg <= wide_merge_enable_next;
            prdata_reg <= prdata_next;
        end
    end

    // Pad drive; analog select does not block the digital driver
    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            for (int b = 0; b < PW; b++)
            begin
                // Open-drain drives only low, else floats
                if (open_drain_ctrl_reg[p][b])
                begin
                    pin_out[p*PW+b] = 1'b0;
                    pin_oe_n[p*PW+b] = direction_reg[p][b]
                        | output_latch_reg[p][b];
                end
                else
                begin
                    pin_out[p*PW+b] = output_latch_reg[p][b];
                    pin_oe_n[p*PW+b] = direction_reg[p][b];
                end
            end
            analog_mode[p*PW +: PW] = analog_select_reg[p];
            // Level request; flags are sticky until software clears them
            change_irq[p] = change_notify_ctrl_reg[p][gpc_pkg::CN_ON_BIT]
                & (|change_event_flag_reg[p]);
        end
    end

    assign prdata = prdata_reg;
endmodule

/* src/gpc_sync.sv */
// Multi-stage pin synchroniser, one instance covers both ports
`timescale 1ns/100ps
module gpc_sync #(
    parameter int WIDTH = 16,
    parameter int STAGES = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // Shift chain; only the last stage is read outside
    logic [WIDTH-1:0] stage_reg [STAGES];
    logic [WIDTH-1:0] stage_next [STAGES];

    // Next values: shift by one stage
    always_comb
    begin
        stage_next[0] = d;
        for (int i = 1; i < STAGES; i++)
        begin
            stage_next[i] = stage_reg[i-1];
        end
    end

    // Register the chain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < STAGES; i++)
            begin
                stage_reg[i] <= '0;
            end
        end
        else
        begin
            stage_reg <= stage_next;
        end
    end

    assign q = stage_reg[STAGES-1];
endmodule

/* verification/gpc_pins.sv */
// Board-side model of the port pins: external drivers and pull-ups
`timescale 1ns/100ps
module gpc_pins #(
    parameter int N = 32
) (
    input wire logic [N-1:0] pin_out,
    input wire logic [N-1:0] pin_oe_n,
    input wire logic [N-1:0] ext_lvl,
    input wire logic [N-1:0] ext_drv,
    output logic [N-1:0] pin_in
);
    // Block wins when it drives; else board driver, else pull-up
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_drv[i])
                pin_in[i] = ext_lvl[i];
            else
                pin_in[i] = 1'b1; // Lifts released drains
        end
    end
endmodule

/* verification/gpc_port_monitor.sv */
// Checker for the two-port GPIO block, bound onto its top module
`timescale 1ns/100ps
module gpc_port_monitor #(
    parameter int PW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2*PW-1:0] pin_in,
    input wire logic [2*PW-1:0] pin_out,
    input wire logic [2*PW-1:0] pin_oe_n,
    input wire logic [2*PW-1:0] analog_mode,
    input wire logic [1:0] change_irq
);
    // Access-phase strobes; pready is tied high so access ends at once
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    // Register offset, alias field and lower-port select
    wire [7:0] off = {paddr[7:4], 4'h0};
    wire [1:0] al = paddr[3:2];
    wire lo = ~paddr[8];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Pins and analog mode quiet long enough to cross the synchroniser
    sequence pins_calm;
        ($stable(pin_in[15:0]) && $stable(analog_mode[15:0]))[*4];
    endsequence
    // Base read of the lower pin-level register
    sequence pin_read_lo;
        rd && lo && off == gpc_pkg::PIN_OFF && al == gpc_pkg::AL_BASE;
    endsequence

    rst_dir_a: assert property (
        $rose(presetn) |-> pin_oe_n == '1)
        else $error("pins not all inputs after reset");
    rst_ana_a: assert property (
        $rose(presetn) |-> analog_mode == '1)
        else $error("analog select not all ones after reset");
    rst_irq_a: assert property (
        $rose(presetn) |-> change_irq == 2'h0)
        else $error("change request active after reset");
    pin_read_a: assert property (
        pins_calm ##0 pin_read_lo |-> prdata ==
        {16'h0, pin_in[15:0] & ~analog_mode[15:0]})
        else $error("pin read value wrong");
    dir_set_a: assert property (
        wr && lo && off == gpc_pkg::DIR_OFF && al == gpc_pkg::AL_SET
        |=> (pin_oe_n[15:0] & $past(pwdata[15:0])) == $past(pwdata[15:0]))
        else $error("pin set to input still driven");
    ana_clr_a: assert property (
        wr && lo && off == gpc_pkg::ANS_OFF && al == gpc_pkg::AL_CLR
        |=> analog_mode[15:0] ==
        ($past(analog_mode[15:0]) & ~$past(pwdata[15:0])))
        else $error("clear alias result wrong");
    ana_inv_a: assert property (
        wr && !lo && off == gpc_pkg::ANS_OFF && al == gpc_pkg::AL_INV
        |=> analog_mode[31:16] ==
        ($past(analog_mode[31:16]) ^ $past(pwdata[15:0])))
        else $error("invert alias result wrong");
    alias_rd_a: assert property (
        rd && al != gpc_pkg::AL_BASE |-> prdata == 32'h0)
        else $error("alias read not zero");
    irq_fall_a: assert property (
        (|($past(change_irq) & ~change_irq)) |-> $past(wr))
        else $error("change request dropped without a write");
    unmapped_a: assert property (
        acc && off > gpc_pkg::WIDE_OFF |-> pslverr)
        else $error("unmapped access not refused");
endmodule

bind gpc_port gpc_port_monitor #(.PW(PW)) i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .analog_mode(analog_mode),
    .change_irq(change_irq)
);

/* verification/tb.sv */
// Self-checking bench for the two-port GPIO block
`timescale 1ns/100ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, pin_in, pin_out, pin_oe_n;
    logic [31:0] analog_mode, ext_lvl, ext_drv;
    logic [1:0] change_irq;
    logic rerr;
    int fail_count, checks_done, cyc;

    gpc_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .analog_mode(analog_mode),
        .change_irq(change_irq));
    gpc_pins i_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_lvl(ext_lvl), .ext_drv(ext_drv), .pin_in(pin_in));

    // 50 MHz clock
    always #10 pclk = ~pclk;

    // Hang guard, far above the few hundred cycles needed
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count = fail_count + 1;
            end_sim();
        end
    end

    // Verdict and end of run
    task end_sim;
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One APB transfer; entered just after an edge; data taken at ready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Compare and count
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task bchk(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    task idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Reset values and a refused address
    task t_reset;
        chk(pin_oe_n, 32'hffffffff);
        rchk(12'h000, 32'hffff);
        rchk(12'h140, 32'hffff);
        rchk(12'h010, 32'h0);
        bchk(rerr, 1'b0);
        rchk(12'h0c0, 32'h0);
        bchk(rerr, 1'b1);
    endtask

    // Both ports digital, merged into one wide view
    task t_wide;
        wr(12'h044, 32'hffff);
        wr(12'h14c, 32'hffff);
        chk(analog_mode, 32'h0);
        ext_lvl <= 32'h1234abcd;
        wr(12'h0a0, 32'h1);
        wr(12'h1a0, 32'h1);
        idle(5);
        rchk(12'h0b0, 32'h1234abcd);
        rchk(12'h1a0, 32'h0);
    endtask

    // Pin change one clock before the access is not yet seen
    task t_lat;
        ext_lvl <= 32'h5a5a0000;
        idle(5);
        rchk(12'h120, 32'h5a5a);
        ext_lvl <= 32'hc3c30000;
        rchk(12'h120, 32'h5a5a);
        idle(5);
        rchk(12'h120, 32'hc3c3);
    endtask

    // Edge modes on pins 0..2, gating, mismatch, status, output pins
    task t_cn;
        int i;
        ext_lvl <= 32'h0;
        wr(12'h050, 32'h8800);
        wr(12'h060, 32'h5);
        wr(12'h070, 32'h6);
        idle(5);
        wr(12'h090, 32'h0);
        for (i = 0; i < 3; i++)
        begin
            ext_lvl[i] <= 1'b1;
            idle(8);
            bchk(change_irq[0], i != 1);
            wr(12'h090, 32'h0);
            ext_lvl[i] <= 1'b0;
            idle(8);
            bchk(change_irq[0], i != 0);
            if (i == 2)
            begin
                wr(12'h050, 32'h0800);
                bchk(change_irq[0], 1'b0);
                wr(12'h050, 32'h8800);
                bchk(change_irq[0], 1'b1);
            end
            wr(12'h090, 32'h0);
        end
        wr(12'h050, 32'h8000);
        wr(12'h060, 32'h8);
        wr(12'h070, 32'h0);
        rchk(12'h020, 32'h0);
        wr(12'h090, 32'h0);
        ext_lvl[3] <= 1'b1;
        idle(8);
        bchk(change_irq[0], 1'b1);
        rchk(12'h080, 32'h8);
        rchk(12'h020, 32'h8);
        rchk(12'h080, 32'h0);
        wr(12'h050, 32'h8800);
        wr(12'h060, 32'h1);
        wr(12'h004, 32'h1);
        idle(8);
        wr(12'h090, 32'h0);
        wr(12'h018, 32'h1);
        idle(8);
        bchk(change_irq[0], 1'b0);
    endtask

    // Direction aliases, latch, open drain and analog outputs
    task t_out;
        ext_drv <= 32'h0;
        wr(12'h000, 32'hffff);
        wr(12'h004, 32'h00ff);
        wr(12'h008, 32'h0030);
        wr(12'h00c, 32'hf0f0);
        rchk(12'h000, 32'h0fc0);
        rchk(12'h00c, 32'h0);
        chk({16'h0, pin_oe_n[15:0]}, 32'h0fc0);
        wr(12'h020, 32'ha5a5);
        rchk(12'h010, 32'ha5a5);
        chk({16'h0, pin_out[15:0] & 16'hf03f}, 32'ha025);
        wr(12'h030, 32'hf);
        chk({16'h0, pin_oe_n[15:0]}, 32'h0fc5);
        chk({28'h0, pin_out[3:0]}, 32'h0);
        idle(5);
        rchk(12'h020, 32'hafe5);
        wr(12'h048, 32'h20);
        chk({30'h0, pin_out[5], pin_oe_n[5]}, 32'h2);
        idle(5);
        rchk(12'h020, 32'hafc5);
    endtask

    // Main sequence
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_lvl = 32'h0;
        ext_drv = 32'hffffffff;
        fail_count = 0;
        checks_done = 0;
        cyc = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        idle(1);
        t_reset();
        t_wide();
        t_lat();
        t_cn();
        t_out();
        end_sim();
    end
endmodule
